// ===== shared/bitbr_pkg.sv
// Shared types, timing table and helpers for the bit-test branch and CPU control executor
package bitbr_pkg;

   // ----------------------------------------------------------------
   // Widths and limits
   // ----------------------------------------------------------------
   localparam int CNT_W = 5;
   localparam int DIV_W = 4;
   localparam int ELAPSED_W = 9;
   localparam logic [2:0] SEL_MAX = 3'h4;
   localparam logic [7:0] BIT_ONE = 8'h01;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // ----------------------------------------------------------------
   // Operations, operand forms and register pairs
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_BRANCH_IF_BIT_SET = 3'b000,
      OP_BRANCH_IF_BIT_CLEAR = 3'b001,
      OP_BRANCH_AND_CLEAR_BIT = 3'b010,
      OP_DECREMENT_BRANCH_NONZERO = 3'b011,
      OP_ENABLE_INTERRUPTS = 3'b100,
      OP_DISABLE_INTERRUPTS = 3'b101,
      OP_WORD_MOVE = 3'b110,
      OP_NONE = 3'b111
   } exec_op_t;

   typedef enum logic [2:0] {
      FORM_SADDR = 3'b000,
      FORM_SFR = 3'b001,
      FORM_ACC = 3'b010,
      FORM_PSW = 3'b011,
      FORM_HL = 3'b100,
      FORM_REG_B = 3'b101,
      FORM_REG_C = 3'b110,
      FORM_NONE = 3'b111
   } operand_form_t;

   typedef enum logic [1:0] {
      PAIR_AX = 2'b00,
      PAIR_BC = 2'b01,
      PAIR_DE = 2'b10,
      PAIR_HL = 2'b11
   } register_pair_t;

   // ----------------------------------------------------------------
   // Request and answer carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      exec_op_t op;
      operand_form_t form;
      logic [2:0] bit_sel;
      logic [15:0] pc;
      logic [7:0] relative_displacement;
      logic [7:0] operand;
      logic fast_ram;
      register_pair_t register_pair;
   } exec_req_t;

   typedef struct packed {
      logic taken;
      logic [15:0] next_pc;
      logic write_en;
      logic [7:0] write_data;
      logic illegal;
   } exec_rsp_t;

   // ----------------------------------------------------------------
   // Length and cycle table: fast RAM figure, then other-area figure
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] len;
      logic [CNT_W-1:0] cyc_fast;
      logic [CNT_W-1:0] cyc_slow;
   } timing_t;

   localparam timing_t T_BT_SADDR = '{3'h3, 5'h08, 5'h09};
   localparam timing_t T_BT_SFR = '{3'h4, 5'h0b, 5'h0b};
   localparam timing_t T_BT_ACC = '{3'h3, 5'h08, 5'h08};
   localparam timing_t T_BT_PSW = '{3'h3, 5'h09, 5'h09};
   localparam timing_t T_BT_HL = '{3'h3, 5'h0a, 5'h0b};
   localparam timing_t T_BF_SADDR = '{3'h4, 5'h0a, 5'h0b};
   localparam timing_t T_BF_SFR = '{3'h4, 5'h0b, 5'h0b};
   localparam timing_t T_BF_ACC = '{3'h3, 5'h08, 5'h08};
   localparam timing_t T_BF_PSW = '{3'h4, 5'h0b, 5'h0b};
   localparam timing_t T_BF_HL = '{3'h3, 5'h0a, 5'h0b};
   localparam timing_t T_BC_SADDR = '{3'h4, 5'h0a, 5'h0c};
   localparam timing_t T_BC_SFR = '{3'h4, 5'h0c, 5'h0c};
   localparam timing_t T_BC_ACC = '{3'h3, 5'h08, 5'h08};
   localparam timing_t T_BC_PSW = '{3'h4, 5'h0c, 5'h0c};
   localparam timing_t T_BC_HL = '{3'h3, 5'h0a, 5'h0c};
   localparam timing_t T_DECREMENT_BRANCH_NONZERO_REG = '{3'h2, 5'h06, 5'h06};
   localparam timing_t T_DECREMENT_BRANCH_NONZERO_SADDR = '{3'h3, 5'h08, 5'h0a};
   localparam timing_t T_IE_OP = '{3'h2, 5'h06, 5'h06};
   localparam timing_t T_REJECT = '{3'h0, 5'h01, 5'h01};

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [2:0] clamp_sel(input logic [2:0] sel);
      clamp_sel = (sel > SEL_MAX) ? SEL_MAX : sel;
   endfunction : clamp_sel

   function automatic logic [15:0] target_pc(input logic [15:0] pc, input logic [2:0] len,
                                             input logic [7:0] disp, input logic taken);
      logic [15:0] ext;
      ext = {{8{disp[7]}}, disp};
      target_pc = pc + {13'h0000, len} + (taken ? ext : 16'h0000);
   endfunction : target_pc

endpackage : bitbr_pkg

// ===== verilog/exec_timer.sv
// Execution timer: CPU-clock enable divider and instruction cycle down-counter
`timescale 1ns/1ps
`default_nettype none
module exec_timer #(
   parameter int CNT_W = bitbr_pkg::CNT_W,
   parameter int DIV_W = bitbr_pkg::DIV_W
) (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic start_in,
   input wire logic [CNT_W-1:0] count_in,
   input wire logic [2:0] clock_select_in,
   output logic expire_out
);
   import bitbr_pkg::*;

   logic [DIV_W-1:0] div_q, div_d, mask;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [2:0] sel_q, sel_d;
   logic cpu_en;

   // ----------------------------------------------------------------
   // Divider and counter
   // ----------------------------------------------------------------
   // Rate is latched at start so a mid-instruction change cannot skew the count
   always_comb begin
      mask = DIV_W'((1 << sel_q) - 1);
      cpu_en = ((div_q & mask) == mask);
      div_d = div_q + {{(DIV_W-1){1'b0}}, 1'b1};
      cnt_d = cnt_q;
      sel_d = sel_q;
      if (start_in) begin
         div_d = '0;
         cnt_d = count_in;
         sel_d = clamp_sel(clock_select_in);
      end else if (cpu_en && cnt_q != '0) begin
         cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
      end
      expire_out = !start_in && cpu_en && (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         div_q <= '0;
         cnt_q <= '0;
         sel_q <= 3'h0;
      end else begin
         div_q <= div_d;
         cnt_q <= cnt_d;
         sel_q <= sel_d;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_cpu_rate;
      @(posedge sys_clk_in) disable iff (!reset_n_in)
      (cpu_en && sel_q != 3'h0 && !start_in) |=> !cpu_en;
   endproperty
   a_cpu_rate: assert property (p_cpu_rate) else $error("CPU enable faster than selected rate");

endmodule : exec_timer
`default_nettype wire

// ===== verilog/bit_test_branch_cpu_control_exec.sv
// Executor for bit-test branches, decrement loops, interrupt enable control and word-move checks
//
// Contract
// - Set-branch on saddr bit: 3 bytes, 8/9
// - Set-branch on sfr bit: 4 bytes, 11
// - Clear-branch on saddr bit: 4 bytes, 10/11
// - Clear-branch on status bit: 4 bytes, 11
// - Branch-and-clear saddr bit: +4, 10/12, clears
// - Branch-and-clear sfr bit: 4 bytes, 12
// - Branch-and-clear accumulator bit: 3 bytes, 8
// - Branch-and-clear status bit: 12, flags may change
// - Loop on B or C: 2 bytes, 6
// - Loop on saddr byte: 3 bytes, 8/10
// - Enable op sets interrupt flag, 6 cycles
// - Disable op clears interrupt flag, 6 cycles
// - Cycles counted in selected CPU clock periods
// - Slow figure applies outside fast RAM
// - Word move to pair only BC/DE/HL
`timescale 1ns/1ps
`default_nettype none
module bit_test_branch_cpu_control_exec (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic start_in,
   input wire bitbr_pkg::exec_req_t req_in,
   input wire logic [2:0] processor_clock_select_in,
   output logic busy_out,
   output logic done_out,
   output bitbr_pkg::exec_rsp_t rsp_out,
   output logic interrupt_enable_flag_out
);
   import bitbr_pkg::*;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } exec_state_t;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   function automatic timing_t bit_timing(input operand_form_t f, input timing_t s_saddr,
                                          input timing_t s_sfr, input timing_t s_acc,
                                          input timing_t s_psw, input timing_t s_hl);
      case (f)
         FORM_SADDR: bit_timing = s_saddr;
         FORM_SFR: bit_timing = s_sfr;
         FORM_ACC: bit_timing = s_acc;
         FORM_PSW: bit_timing = s_psw;
         default: bit_timing = s_hl;
      endcase
   endfunction : bit_timing

   timing_t t;
   logic legal, taken, wen, bit_val, new_ie, is_bit_form;
   logic [7:0] wdata, dec;
   logic [CNT_W-1:0] cyc;

   always_comb begin
      t = T_REJECT;
      legal = 1'b0;
      taken = 1'b0;
      wen = 1'b0;
      wdata = req_in.operand;
      new_ie = interrupt_enable_flag_out;
      bit_val = req_in.operand[req_in.bit_sel];
      dec = req_in.operand - BYTE_ONE;
      is_bit_form = (req_in.form <= FORM_HL);
      case (req_in.op)
         OP_BRANCH_IF_BIT_SET: begin
            legal = is_bit_form;
            t = bit_timing(req_in.form, T_BT_SADDR, T_BT_SFR, T_BT_ACC, T_BT_PSW, T_BT_HL);
            taken = bit_val;
         end
         OP_BRANCH_IF_BIT_CLEAR: begin
            legal = is_bit_form;
            t = bit_timing(req_in.form, T_BF_SADDR, T_BF_SFR, T_BF_ACC, T_BF_PSW, T_BF_HL);
            taken = !bit_val;
         end
         OP_BRANCH_AND_CLEAR_BIT: begin
            legal = is_bit_form;
            t = bit_timing(req_in.form, T_BC_SADDR, T_BC_SFR, T_BC_ACC, T_BC_PSW, T_BC_HL);
            taken = bit_val;
            // Status-word form writes back the whole word, so its flags may change
            wen = bit_val;
            wdata = req_in.operand & ~(BIT_ONE << req_in.bit_sel);
         end
         OP_DECREMENT_BRANCH_NONZERO: begin
            legal = (req_in.form == FORM_SADDR) || (req_in.form == FORM_REG_B) || (req_in.form == FORM_REG_C);
            t = (req_in.form == FORM_SADDR) ? T_DECREMENT_BRANCH_NONZERO_SADDR : T_DECREMENT_BRANCH_NONZERO_REG;
            wen = 1'b1;
            wdata = dec;
            taken = (dec != BYTE_ZERO);
         end
         OP_ENABLE_INTERRUPTS: begin
            legal = 1'b1;
            t = T_IE_OP;
            new_ie = 1'b1;
         end
         OP_DISABLE_INTERRUPTS: begin
            legal = 1'b1;
            t = T_IE_OP;
            new_ie = 1'b0;
         end
         OP_WORD_MOVE: begin
            // Only the legality of the destination pair is judged here
            legal = (req_in.register_pair != PAIR_AX);
         end
         default: begin
            legal = 1'b0;
         end
      endcase
      if (!legal) begin
         t = T_REJECT;
         taken = 1'b0;
         wen = 1'b0;
         new_ie = interrupt_enable_flag_out;
      end
      cyc = req_in.fast_ram ? t.cyc_fast : t.cyc_slow;
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   exec_state_t state_q, state_d;
   exec_rsp_t pend_q, pend_d, rsp_d;
   logic pend_ie_q, pend_ie_d, ie_d, busy_d, done_d, timer_start, expire;

   always_comb begin
      state_d = state_q;
      pend_d = pend_q;
      pend_ie_d = pend_ie_q;
      rsp_d = rsp_out;
      ie_d = interrupt_enable_flag_out;
      busy_d = busy_out;
      done_d = 1'b0;
      timer_start = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (start_in) begin
               pend_d.taken = taken;
               pend_d.next_pc = target_pc(req_in.pc, t.len, req_in.relative_displacement, taken);
               pend_d.write_en = wen;
               pend_d.write_data = wdata;
               pend_d.illegal = !legal;
               pend_ie_d = new_ie;
               timer_start = 1'b1;
               busy_d = 1'b1;
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            // Results appear only when the instruction's full cycle count has run out
            if (expire) begin
               rsp_d = pend_q;
               ie_d = pend_ie_q;
               done_d = 1'b1;
               busy_d = 1'b0;
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q <= ST_IDLE;
         pend_q <= '0;
         pend_ie_q <= 1'b0;
         rsp_out <= '0;
         interrupt_enable_flag_out <= 1'b0;
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         state_q <= state_d;
         pend_q <= pend_d;
         pend_ie_q <= pend_ie_d;
         rsp_out <= rsp_d;
         interrupt_enable_flag_out <= ie_d;
         busy_out <= busy_d;
         done_out <= done_d;
      end
   end

   exec_timer #(
      .CNT_W(CNT_W),
      .DIV_W(DIV_W)
   ) u_timer (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .start_in(timer_start),
      .count_in(cyc),
      .clock_select_in(processor_clock_select_in),
      .expire_out(expire)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   exec_req_t chk_req_q;
   logic [2:0] chk_sel_q;
   logic [ELAPSED_W-1:0] elapsed_q;
   logic [ELAPSED_W-1:0] chk_fast_time, chk_slow_time;

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         chk_req_q <= '0;
         chk_sel_q <= 3'h0;
         elapsed_q <= '0;
      end else if (timer_start) begin
         chk_req_q <= req_in;
         chk_sel_q <= clamp_sel(processor_clock_select_in);
         elapsed_q <= '0;
      end else if (busy_out) begin
         elapsed_q <= elapsed_q + {{(ELAPSED_W-1){1'b0}}, 1'b1};
      end
   end

   function automatic logic [ELAPSED_W-1:0] scaled(input logic [CNT_W-1:0] c, input logic [2:0] s);
      scaled = ELAPSED_W'({4'h0, c} << s);
   endfunction : scaled

   assign chk_fast_time = scaled(chk_req_q.fast_ram ? 5'h08 : 5'h09, chk_sel_q);
   assign chk_slow_time = scaled(chk_req_q.fast_ram ? 5'h0a : 5'h0b, chk_sel_q);

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);

   property p_bt_saddr;
      done_out && chk_req_q.op == OP_BRANCH_IF_BIT_SET && chk_req_q.form == FORM_SADDR |->
      elapsed_q == chk_fast_time && rsp_out.next_pc == target_pc(chk_req_q.pc, 3'h3,
      chk_req_q.relative_displacement, chk_req_q.operand[chk_req_q.bit_sel]);
   endproperty
   a_bt_saddr: assert property (p_bt_saddr) else $error("Bit-set saddr branch wrong");

   property p_bt_sfr;
      done_out && chk_req_q.op == OP_BRANCH_IF_BIT_SET && chk_req_q.form == FORM_SFR |->
      elapsed_q == scaled(5'h0b, chk_sel_q) && rsp_out.taken == chk_req_q.operand[chk_req_q.bit_sel];
   endproperty
   a_bt_sfr: assert property (p_bt_sfr) else $error("Bit-set sfr branch wrong");

   property p_bf_saddr;
      done_out && chk_req_q.op == OP_BRANCH_IF_BIT_CLEAR && chk_req_q.form == FORM_SADDR |->
      elapsed_q == chk_slow_time && rsp_out.taken != chk_req_q.operand[chk_req_q.bit_sel];
   endproperty
   a_bf_saddr: assert property (p_bf_saddr) else $error("Bit-clear saddr branch wrong");

   property p_bf_psw;
      done_out && chk_req_q.op == OP_BRANCH_IF_BIT_CLEAR && chk_req_q.form == FORM_PSW |->
      elapsed_q == scaled(5'h0b, chk_sel_q) && rsp_out.next_pc == target_pc(chk_req_q.pc, 3'h4,
      chk_req_q.relative_displacement, !chk_req_q.operand[chk_req_q.bit_sel]);
   endproperty
   a_bf_psw: assert property (p_bf_psw) else $error("Bit-clear status branch wrong");

   property p_clr_saddr;
      start_in && !busy_out && req_in.op == OP_BRANCH_AND_CLEAR_BIT && req_in.form == FORM_SADDR &&
      req_in.operand[req_in.bit_sel] |-> ##[2:200] done_out && rsp_out.write_en &&
      !rsp_out.write_data[chk_req_q.bit_sel] && rsp_out.taken;
   endproperty
   a_clr_saddr: assert property (p_clr_saddr) else $error("Branch-and-clear saddr wrong");

   property p_clr_sfr;
      done_out && chk_req_q.op == OP_BRANCH_AND_CLEAR_BIT && chk_req_q.form == FORM_SFR |->
      elapsed_q == scaled(5'h0c, chk_sel_q) && rsp_out.write_en == rsp_out.taken;
   endproperty
   a_clr_sfr: assert property (p_clr_sfr) else $error("Branch-and-clear sfr wrong");

   property p_clr_acc;
      done_out && chk_req_q.op == OP_BRANCH_AND_CLEAR_BIT && chk_req_q.form == FORM_ACC && rsp_out.taken |->
      elapsed_q == scaled(5'h08, chk_sel_q) && rsp_out.next_pc == target_pc(chk_req_q.pc, 3'h3,
      chk_req_q.relative_displacement, 1'b1);
   endproperty
   a_clr_acc: assert property (p_clr_acc) else $error("Branch-and-clear accumulator wrong");

   property p_clr_psw;
      done_out && chk_req_q.op == OP_BRANCH_AND_CLEAR_BIT && chk_req_q.form == FORM_PSW |->
      elapsed_q == scaled(5'h0c, chk_sel_q);
   endproperty
   a_clr_psw: assert property (p_clr_psw) else $error("Branch-and-clear status timing wrong");

   property p_decrement_branch_nonzero;
      done_out && chk_req_q.op == OP_DECREMENT_BRANCH_NONZERO && !rsp_out.illegal |->
      rsp_out.write_data == chk_req_q.operand - BYTE_ONE && rsp_out.taken == (rsp_out.write_data != BYTE_ZERO);
   endproperty
   a_decrement_branch_nonzero: assert property (p_decrement_branch_nonzero) else $error("Loop decrement or test wrong");

   property p_ei;
      start_in && !busy_out && req_in.op == OP_ENABLE_INTERRUPTS && processor_clock_select_in == 3'h0 |->
      ##7 done_out && interrupt_enable_flag_out;
   endproperty
   a_ei: assert property (p_ei) else $error("Enable op did not set flag in 6 cycles");

   property p_di;
      start_in && !busy_out && req_in.op == OP_DISABLE_INTERRUPTS && processor_clock_select_in == 3'h0 |->
      ##7 done_out && !interrupt_enable_flag_out;
   endproperty
   a_di: assert property (p_di) else $error("Disable op did not clear flag in 6 cycles");

   property p_word_move;
      done_out && chk_req_q.op == OP_WORD_MOVE |-> rsp_out.illegal == (chk_req_q.register_pair == PAIR_AX);
   endproperty
   a_word_move: assert property (p_word_move) else $error("Word move pair check wrong");

   property p_not_taken;
      done_out && !rsp_out.taken && !rsp_out.illegal && chk_req_q.op == OP_DECREMENT_BRANCH_NONZERO &&
      (chk_req_q.form == FORM_REG_B || chk_req_q.form == FORM_REG_C) |->
      rsp_out.next_pc == chk_req_q.pc + 16'h0002;
   endproperty
   a_not_taken: assert property (p_not_taken) else $error("Fall-through address wrong");

endmodule : bit_test_branch_cpu_control_exec
`default_nettype wire

// ===== verif/data_space_model.sv
// Behavioural data space: holds the tested byte and takes write-backs from the executor
`timescale 1ns/1ps
`default_nettype none
module data_space_model (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic load_in,
   input wire logic [7:0] load_data_in,
   input wire logic done_in,
   input wire bitbr_pkg::exec_rsp_t rsp_in,
   output logic [7:0] operand_out
);
   import bitbr_pkg::*;

   logic [7:0] byte_q;
   logic [7:0] byte_d;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Write-back lands only on the done pulse, as a real memory port would take it
   always_comb begin
      byte_d = byte_q;
      if (load_in) begin
         byte_d = load_data_in;
      end else if (done_in && rsp_in.write_en) begin
         byte_d = rsp_in.write_data;
      end
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         byte_q <= 8'h00;
      end else begin
         byte_q <= byte_d;
      end
   end

   assign operand_out = byte_q;
endmodule : data_space_model
`default_nettype wire

// ===== verif/tb_bit_test_branch_cpu_control_exec.sv
// Self-checking bench for the bit-test branch and CPU control executor
`timescale 1ns/1ps
`default_nettype none
module tb_bit_test_branch_cpu_control_exec;
   import bitbr_pkg::*;

   logic sys_clk_in;
   logic reset_n_in;
   logic start_in;
   exec_req_t req_drv;
   exec_req_t req_in;
   logic [2:0] sel;
   logic busy_out;
   logic done_out;
   exec_rsp_t rsp_out;
   logic flag;
   logic load;
   logic [7:0] load_data;
   logic [7:0] operand;
   int fail_count;
   int n_tests;

   always_comb begin
      req_in = req_drv;
      req_in.operand = operand;
   end

   bit_test_branch_cpu_control_exec u_bit_test_branch_cpu_control_exec (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .start_in(start_in),
      .req_in(req_in),
      .processor_clock_select_in(sel),
      .busy_out(busy_out),
      .done_out(done_out),
      .rsp_out(rsp_out),
      .interrupt_enable_flag_out(flag)
   );

   data_space_model u_data_space_model (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .load_in(load),
      .load_data_in(load_data),
      .done_in(done_out),
      .rsp_in(rsp_out),
      .operand_out(operand)
   );

   initial begin
      sys_clk_in = 1'b0;
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end

   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   // ----------------------------------------------------------------
   // One instruction: load operand, issue, time it, compare the answer
   // ----------------------------------------------------------------
   task automatic run(input exec_op_t op, input operand_form_t f, input logic [2:0] b, input logic [7:0] disp,
                      input logic [7:0] opd, input logic fast, input register_pair_t rp, input int n,
                      input logic tk, input logic [15:0] npc);
      int k;
      logic [15:0] e;
      e = 16'(n << ((sel > 3'h4) ? 3'h4 : sel));
      @(negedge sys_clk_in);
      load = 1'b1;
      load_data = opd;
      @(negedge sys_clk_in);
      load = 1'b0;
      req_drv.op = op;
      req_drv.form = f;
      req_drv.bit_sel = b;
      req_drv.pc = 16'h0100;
      req_drv.relative_displacement = disp;
      req_drv.fast_ram = fast;
      req_drv.register_pair = rp;
      start_in = 1'b1;
      @(negedge sys_clk_in);
      start_in = 1'b0;
      check(16'(busy_out), 16'h0001);
      k = 0;
      while (done_out !== 1'b1 && k < 400) begin
         @(negedge sys_clk_in);
         k++;
      end
      if (k >= 400) begin
         fail_count++;
         $display("Error at %0t: no completion", $time);
         test_done();
      end
      check(16'(k), e);
      if (op < OP_ENABLE_INTERRUPTS) begin
         check(16'(rsp_out.taken), 16'(tk));
         check(rsp_out.next_pc, npc);
      end
      // Write-back lands in the data space one edge after the done pulse
      @(negedge sys_clk_in);
      $display("op %0d form %0d finished after %0d cycles", op, f, k);
   endtask : run

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      fail_count = 0;
      n_tests = 0;
      reset_n_in = 1'b0;
      start_in = 1'b0;
      req_drv = '0;
      sel = 3'h0;
      load = 1'b0;
      load_data = 8'h00;
      repeat (3) @(negedge sys_clk_in);
      reset_n_in = 1'b1;
      check(16'(flag), 16'h0000);
      run(OP_BRANCH_IF_BIT_SET, FORM_SADDR, 3'h2, 8'hFE, 8'h04, 1'b1, PAIR_AX, 8, 1'b1, 16'h0101);
      run(OP_BRANCH_IF_BIT_SET, FORM_SADDR, 3'h2, 8'hFE, 8'hFB, 1'b0, PAIR_AX, 9, 1'b0, 16'h0103);
      run(OP_BRANCH_IF_BIT_SET, FORM_SFR, 3'h7, 8'h10, 8'h80, 1'b0, PAIR_AX, 11, 1'b1, 16'h0114);
      run(OP_BRANCH_IF_BIT_CLEAR, FORM_SADDR, 3'h0, 8'h80, 8'hFE, 1'b1, PAIR_AX, 10, 1'b1, 16'h0084);
      run(OP_BRANCH_IF_BIT_CLEAR, FORM_SADDR, 3'h0, 8'h80, 8'h01, 1'b0, PAIR_AX, 11, 1'b0, 16'h0104);
      run(OP_BRANCH_IF_BIT_CLEAR, FORM_PSW, 3'h1, 8'h05, 8'h00, 1'b1, PAIR_AX, 11, 1'b1, 16'h0109);
      run(OP_BRANCH_AND_CLEAR_BIT, FORM_SADDR, 3'h3, 8'h00, 8'h08, 1'b1, PAIR_AX, 10, 1'b1, 16'h0104);
      check(16'(operand), 16'h0000);
      run(OP_BRANCH_AND_CLEAR_BIT, FORM_SADDR, 3'h3, 8'h00, 8'h08, 1'b0, PAIR_AX, 12, 1'b1, 16'h0104);
      run(OP_BRANCH_AND_CLEAR_BIT, FORM_SFR, 3'h5, 8'h00, 8'hFF, 1'b1, PAIR_AX, 12, 1'b1, 16'h0104);
      check(16'(operand), 16'h00DF);
      run(OP_BRANCH_AND_CLEAR_BIT, FORM_ACC, 3'h0, 8'h00, 8'h01, 1'b1, PAIR_AX, 8, 1'b1, 16'h0103);
      check(16'(operand), 16'h0000);
      run(OP_BRANCH_AND_CLEAR_BIT, FORM_ACC, 3'h0, 8'h00, 8'h00, 1'b1, PAIR_AX, 8, 1'b0, 16'h0103);
      run(OP_BRANCH_AND_CLEAR_BIT, FORM_PSW, 3'h6, 8'h00, 8'h41, 1'b0, PAIR_AX, 12, 1'b1, 16'h0104);
      check(16'(operand), 16'h0001);
      run(OP_DECREMENT_BRANCH_NONZERO, FORM_REG_B, 3'h0, 8'hFC, 8'h02, 1'b1, PAIR_AX, 6, 1'b1, 16'h00FE);
      check(16'(operand), 16'h0001);
      run(OP_DECREMENT_BRANCH_NONZERO, FORM_REG_C, 3'h0, 8'hFC, 8'h01, 1'b1, PAIR_AX, 6, 1'b0, 16'h0102);
      check(16'(operand), 16'h0000);
      run(OP_DECREMENT_BRANCH_NONZERO, FORM_SADDR, 3'h0, 8'h02, 8'h00, 1'b1, PAIR_AX, 8, 1'b1, 16'h0105);
      run(OP_DECREMENT_BRANCH_NONZERO, FORM_SADDR, 3'h0, 8'h02, 8'h05, 1'b0, PAIR_AX, 10, 1'b1, 16'h0105);
      run(OP_ENABLE_INTERRUPTS, FORM_NONE, 3'h0, 8'h00, 8'h00, 1'b1, PAIR_AX, 6, 1'b0, 16'h0000);
      check(16'(flag), 16'h0001);
      run(OP_DISABLE_INTERRUPTS, FORM_NONE, 3'h0, 8'h00, 8'h00, 1'b1, PAIR_AX, 6, 1'b0, 16'h0000);
      check(16'(flag), 16'h0000);
      sel = 3'h2;
      run(OP_ENABLE_INTERRUPTS, FORM_NONE, 3'h0, 8'h00, 8'h00, 1'b1, PAIR_AX, 6, 1'b0, 16'h0000);
      check(16'(flag), 16'h0001);
      sel = 3'h7;
      run(OP_DISABLE_INTERRUPTS, FORM_NONE, 3'h0, 8'h00, 8'h00, 1'b1, PAIR_AX, 6, 1'b0, 16'h0000);
      sel = 3'h0;
      for (int p = 0; p < 4; p++) begin
         run(OP_WORD_MOVE, FORM_NONE, 3'h0, 8'h00, 8'h00, 1'b1, register_pair_t'(p), 1, 1'b0, 16'h0100);
         check(16'(rsp_out.illegal), (p == 0) ? 16'h0001 : 16'h0000);
         check(rsp_out.next_pc, 16'h0100);
      end
      test_done();
   end
endmodule : tb_bit_test_branch_cpu_control_exec
`default_nettype wire
